// [rtl/ipe_irq_ctrl.sv]
// file: port A/C interrupt edge capture, priority and master enable
//
// The plain strobed port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module ipe_irq_ctrl
(
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic [11:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic [7:0] port_a_line,
    input wire logic [3:0] port_c_line,
    input wire ipe_pkg::ipe_core_op_t core_op,
    output ipe_pkg::ipe_req_t core_req,
    output logic master_request_enable,
    output logic irq_out
);

    // synchroniser stages: first is read only by the second
    logic [7:0] pa_meta_r;
    logic [7:0] pa_sync_r;
    logic [7:0] pa_prev_r;
    logic [3:0] pc_meta_r;
    logic [3:0] pc_sync_r;
    logic [3:0] pc_prev_r;

    // software registers
    logic [3:0] portc_prio_high_reg_r;
    logic [3:0] portc_prio_high_reg_nxt;
    logic [3:0] portc_prio_low_reg_r;
    logic [3:0] portc_prio_low_reg_nxt;
    logic [7:0] edge_polarity_reg_r;
    logic [7:0] edge_polarity_reg_nxt;
    logic master_enable_r;
    logic master_enable_nxt;

    // sticky event status and masks
    logic [7:0] pa_status_r;
    logic [7:0] pa_status_nxt;
    logic [3:0] pc_status_r;
    logic [3:0] pc_status_nxt;
    logic [7:0] pa_mask_r;
    logic [7:0] pa_mask_nxt;
    logic [3:0] pc_mask_r;
    logic [3:0] pc_mask_nxt;

    // bus read data and outward flops
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;
    logic irq_r;
    logic irq_nxt;
    ipe_pkg::ipe_req_t req_r;
    ipe_pkg::ipe_req_t req_nxt;

    // one-cycle edge events
    logic [7:0] pa_event;
    logic [3:0] pc_event;

    // write decodes
    logic wr_prio_high;
    logic wr_prio_low;
    logic wr_polarity;
    logic wr_control;
    logic wr_pa_status;
    logic wr_pc_status;
    logic wr_pa_mask;
    logic wr_pc_mask;

    // acknowledge clears the pending bit of the serviced line
    logic [3:0] ack_clear;

    // input synchronisers plus one history stage for edge detection
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pa_meta_r <= 8'h00;
            pa_sync_r <= 8'h00;
            pa_prev_r <= 8'h00;
            pc_meta_r <= 4'h0;
            pc_sync_r <= 4'h0;
            pc_prev_r <= 4'h0;
        end
        else
        begin
            pa_meta_r <= port_a_line;
            pa_sync_r <= pa_meta_r;
            pa_prev_r <= pa_sync_r;
            pc_meta_r <= port_c_line;
            pc_sync_r <= pc_meta_r;
            pc_prev_r <= pc_sync_r;
        end
    end

    // per-line edge select on port A
    // a level held for one sampled clock survives the synchroniser, so
    // anything wider than one period is seen; shorter pulses may vanish
    genvar gi;
    generate
        for (gi = 0; gi < ipe_pkg::PORTA_LINES; gi++)
        begin : g_pa_edge
            always_comb
            begin
                if (edge_polarity_reg_r[gi])
                begin
                    // rising edge
                    pa_event[gi] = pa_sync_r[gi] & ~pa_prev_r[gi];
                end
                else
                begin
                    // falling edge
                    pa_event[gi] = ~pa_sync_r[gi] & pa_prev_r[gi];
                end
            end
        end
    endgenerate

    // port C sources request on a rising edge
    assign pc_event = pc_sync_r & ~pc_prev_r;

    // address decode for writes
    always_comb
    begin
        wr_prio_high = reg_wr && (reg_addr == ipe_pkg::PORTC_PRIO_HIGH_ADDR);
        wr_prio_low = reg_wr && (reg_addr == ipe_pkg::PORTC_PRIO_LOW_ADDR);
        wr_polarity = reg_wr && (reg_addr == ipe_pkg::EDGE_POLARITY_ADDR);
        wr_control = reg_wr && (reg_addr == ipe_pkg::REQUEST_CONTROL_ADDR);
        wr_pa_status = reg_wr && (reg_addr == ipe_pkg::PORTA_STATUS_ADDR);
        wr_pc_status = reg_wr && (reg_addr == ipe_pkg::PORTC_STATUS_ADDR);
        wr_pa_mask = reg_wr && (reg_addr == ipe_pkg::PORTA_MASK_ADDR);
        wr_pc_mask = reg_wr && (reg_addr == ipe_pkg::PORTC_MASK_ADDR);
    end

    // acknowledge decode: one-hot of the serviced port C line
    always_comb
    begin
        ack_clear = 4'h0;
        if (core_op.ack)
        begin
            ack_clear[core_op.ack_line] = 1'b1;
        end
    end

    // next values of the software registers
    always_comb
    begin
        // priority pairs keep only bits 3:0; bits 7:4 are dropped
        portc_prio_high_reg_nxt = portc_prio_high_reg_r;
        portc_prio_low_reg_nxt = portc_prio_low_reg_r;
        edge_polarity_reg_nxt = edge_polarity_reg_r;
        pa_mask_nxt = pa_mask_r;
        pc_mask_nxt = pc_mask_r;
        if (wr_prio_high)
        begin
            portc_prio_high_reg_nxt = reg_wdata[3:0];
        end
        if (wr_prio_low)
        begin
            portc_prio_low_reg_nxt = reg_wdata[3:0];
        end
        if (wr_polarity)
        begin
            edge_polarity_reg_nxt = reg_wdata;
        end
        if (wr_pa_mask)
        begin
            pa_mask_nxt = reg_wdata;
        end
        if (wr_pc_mask)
        begin
            pc_mask_nxt = reg_wdata[3:0];
        end
    end

    // next value of the master enable
    // clearing causes win over setting ones in the same cycle: a
    // handler entry must never leave interrupts open by accident
    always_comb
    begin
        master_enable_nxt = master_enable_r;
        if (wr_control)
        begin
            // only bit 7 is writable, bits 6:0 ignored
            master_enable_nxt = reg_wdata[ipe_pkg::MASTER_ENABLE_BIT];
        end
        if (core_op.global_unmask_op || core_op.return_from_handler_op)
        begin
            master_enable_nxt = 1'b1;
        end
        if (core_op.interrupt_mask_op || core_op.ack)
        begin
            master_enable_nxt = 1'b0;
        end
    end

    // sticky status: write one clears, a new edge wins over the clear
    always_comb
    begin
        pa_status_nxt = pa_status_r;
        pc_status_nxt = pc_status_r;
        if (wr_pa_status)
        begin
            pa_status_nxt = pa_status_nxt & ~reg_wdata;
        end
        if (wr_pc_status)
        begin
            pc_status_nxt = pc_status_nxt & ~reg_wdata[3:0];
        end
        pc_status_nxt = pc_status_nxt & ~ack_clear;
        pa_status_nxt = pa_status_nxt | pa_event;
        pc_status_nxt = pc_status_nxt | pc_event;
    end

    // interrupt output: any unmasked sticky bit
    always_comb
    begin
        irq_nxt = |(pa_status_r & pa_mask_r) | |(pc_status_r & pc_mask_r);
    end

    // request selection: best level, lowest line on a tie
    always_comb
    begin
        ipe_pkg::ipe_prio_t lvl;
        lvl = ipe_pkg::IPE_PRIO_OFF;
        req_nxt.valid = 1'b0;
        req_nxt.line = 2'd0;
        req_nxt.level = ipe_pkg::IPE_PRIO_OFF;
        for (int i = 0; i < ipe_pkg::PORTC_LINES; i++)
        begin
            // pair decode: 00 off, 01 low, 10 nominal, 11 high
            lvl = ipe_pkg::ipe_prio_t'({portc_prio_high_reg_r[i],
                portc_prio_low_reg_r[i]});
            if (pc_status_r[i] && (lvl != ipe_pkg::IPE_PRIO_OFF) &&
                (lvl > req_nxt.level))
            begin
                req_nxt.valid = 1'b1;
                req_nxt.line = 2'(i);
                req_nxt.level = lvl;
            end
        end
        // master enable gates every request to the core
        if (!master_enable_r)
        begin
            req_nxt.valid = 1'b0;
            req_nxt.line = 2'd0;
            req_nxt.level = ipe_pkg::IPE_PRIO_OFF;
        end
    end

    // read mux: data appears the cycle after the strobe only
    always_comb
    begin
        rdata_nxt = ipe_pkg::READ_ZERO;
        if (reg_rd)
        begin
            case (reg_addr)
                ipe_pkg::PORTC_PRIO_HIGH_ADDR:
                    rdata_nxt = {4'h0, portc_prio_high_reg_r};
                ipe_pkg::PORTC_PRIO_LOW_ADDR:
                    rdata_nxt = {4'h0, portc_prio_low_reg_r};
                ipe_pkg::EDGE_POLARITY_ADDR:
                    rdata_nxt = edge_polarity_reg_r;
                ipe_pkg::REQUEST_CONTROL_ADDR:
                    rdata_nxt = {master_enable_r, 7'h00};
                ipe_pkg::PORTA_STATUS_ADDR:
                    rdata_nxt = pa_status_r;
                ipe_pkg::PORTC_STATUS_ADDR:
                    rdata_nxt = {4'h0, pc_status_r};
                ipe_pkg::PORTA_MASK_ADDR:
                    rdata_nxt = pa_mask_r;
                ipe_pkg::PORTC_MASK_ADDR:
                    rdata_nxt = {4'h0, pc_mask_r};
                // unmapped addresses read as zero
                default:
                    rdata_nxt = ipe_pkg::READ_ZERO;
            endcase
        end
    end

    // state registers; reset clears the master enable too
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            portc_prio_high_reg_r <= ipe_pkg::PORTC_PRIO_HIGH_RST[3:0];
            portc_prio_low_reg_r <= ipe_pkg::PORTC_PRIO_LOW_RST[3:0];
            edge_polarity_reg_r <= ipe_pkg::EDGE_POLARITY_RST;
            master_enable_r <= ipe_pkg::REQUEST_CONTROL_RST[7];
            pa_status_r <= ipe_pkg::STATUS_RST;
            pc_status_r <= ipe_pkg::STATUS_RST[3:0];
            pa_mask_r <= ipe_pkg::MASK_RST;
            pc_mask_r <= ipe_pkg::MASK_RST[3:0];
            rdata_r <= ipe_pkg::READ_ZERO;
            irq_r <= 1'b0;
            req_r <= '0;
        end
        else
        begin
            portc_prio_high_reg_r <= portc_prio_high_reg_nxt;
            portc_prio_low_reg_r <= portc_prio_low_reg_nxt;
            edge_polarity_reg_r <= edge_polarity_reg_nxt;
            master_enable_r <= master_enable_nxt;
            pa_status_r <= pa_status_nxt;
            pc_status_r <= pc_status_nxt;
            pa_mask_r <= pa_mask_nxt;
            pc_mask_r <= pc_mask_nxt;
            rdata_r <= rdata_nxt;
            irq_r <= irq_nxt;
            req_r <= req_nxt;
        end
    end

    // outputs straight from flops
    assign reg_rdata = rdata_r;
    assign core_req = req_r;
    assign master_request_enable = master_enable_r;
    assign irq_out = irq_r;

endmodule

`default_nettype wire

// [rtl/ipe_pkg.sv]
// package: register map, field layout, reset values and carrier types
package ipe_pkg;

    // register bus geometry
    localparam int ADDR_W = 12;
    localparam int DATA_W = 8;

    // register offsets
    localparam logic [11:0] PORTC_PRIO_HIGH_ADDR = 12'h0fc7;
    localparam logic [11:0] PORTC_PRIO_LOW_ADDR = 12'h0fc8;
    localparam logic [11:0] EDGE_POLARITY_ADDR = 12'h0fcd;
    localparam logic [11:0] REQUEST_CONTROL_ADDR = 12'h0fcf;
    localparam logic [11:0] PORTA_STATUS_ADDR = 12'h0fd0;
    localparam logic [11:0] PORTC_STATUS_ADDR = 12'h0fd1;
    localparam logic [11:0] PORTA_MASK_ADDR = 12'h0fd2;
    localparam logic [11:0] PORTC_MASK_ADDR = 12'h0fd3;

    // line counts
    localparam int PORTA_LINES = 8;
    localparam int PORTC_LINES = 4;

    // field positions
    localparam int MASTER_ENABLE_BIT = 7;

    // reset values
    localparam logic [7:0] PORTC_PRIO_HIGH_RST = 8'h00;
    localparam logic [7:0] PORTC_PRIO_LOW_RST = 8'h00;
    localparam logic [7:0] EDGE_POLARITY_RST = 8'h00;
    localparam logic [7:0] REQUEST_CONTROL_RST = 8'h00;
    localparam logic [7:0] STATUS_RST = 8'h00;
    localparam logic [7:0] MASK_RST = 8'h00;
    localparam logic [7:0] READ_ZERO = 8'h00;

    // priority encodings of a high/low enable pair
    typedef enum logic [1:0] {
        IPE_PRIO_OFF = 2'b00,
        IPE_PRIO_LOW = 2'b01,
        IPE_PRIO_NOMINAL = 2'b10,
        IPE_PRIO_HIGH = 2'b11
    } ipe_prio_t;

    // operations reported by the core, one-cycle pulses
    typedef struct packed {
        logic global_unmask_op;
        logic return_from_handler_op;
        logic interrupt_mask_op;
        logic ack;
        logic [1:0] ack_line;
    } ipe_core_op_t;

    // request forwarded to the core
    typedef struct packed {
        logic valid;
        logic [1:0] line;
        ipe_prio_t level;
    } ipe_req_t;

endpackage

// [dv/ipe_irq_ctrl_sva.sv]
// checker: port-level properties of the interrupt controller
`timescale 1ns/1ps
`default_nettype none
module ipe_irq_ctrl_sva
(
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic [11:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic [7:0] port_a_line,
    input wire logic [3:0] port_c_line,
    input wire ipe_pkg::ipe_core_op_t core_op,
    input wire ipe_pkg::ipe_req_t core_req,
    input wire logic master_request_enable,
    input wire logic irq_out
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    // enable-clearing and enable-setting core ops
    wire logic clr_op = core_op.interrupt_mask_op | core_op.ack;
    wire logic set_op = core_op.global_unmask_op | core_op.return_from_handler_op;
    // software access to the control and priority registers
    wire logic ctl_wr = reg_wr && (reg_addr == ipe_pkg::REQUEST_CONTROL_ADDR);
    wire logic ctl_rd = reg_rd && (reg_addr == ipe_pkg::REQUEST_CONTROL_ADDR);
    wire logic pri_rd = reg_rd && (reg_addr == ipe_pkg::PORTC_PRIO_HIGH_ADDR
        || reg_addr == ipe_pkg::PORTC_PRIO_LOW_ADDR);

    property p_ctl_rsvd;
        ctl_rd |=> reg_rdata[6:0] == 7'h00;
    endproperty
    a_ctl_rsvd: assert property (p_ctl_rsvd)
        else $error("control reserved bits not zero");
    property p_prio_rsvd;
        pri_rd |=> reg_rdata[7:4] == 4'h0;
    endproperty
    a_prio_rsvd: assert property (p_prio_rsvd)
        else $error("priority reserved bits not zero");
    property p_set;
        set_op && !clr_op |=> master_request_enable;
    endproperty
    a_set: assert property (p_set)
        else $error("enable not set by core op");
    property p_clr;
        clr_op |=> !master_request_enable;
    endproperty
    a_clr: assert property (p_clr)
        else $error("enable not cleared by core op");
    property p_wr;
        ctl_wr && !set_op && !clr_op |=> master_request_enable == $past(reg_wdata[7]);
    endproperty
    a_wr: assert property (p_wr)
        else $error("enable does not follow write");
    property p_gate;
        !master_request_enable && !$past(master_request_enable) |-> !core_req.valid;
    endproperty
    a_gate: assert property (p_gate)
        else $error("request offered while disabled");
    property p_level;
        core_req.valid |-> core_req.level != ipe_pkg::IPE_PRIO_OFF;
    endproperty
    a_level: assert property (p_level)
        else $error("disabled level offered");
    property p_ack_drop;
        core_op.ack ##1 (!set_op && !ctl_wr) [*2] |=> !core_req.valid;
    endproperty
    a_ack_drop: assert property (p_ack_drop)
        else $error("request stays after ack");
endmodule

bind ipe_irq_ctrl ipe_irq_ctrl_sva u_sva
(
    .sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .port_a_line(port_a_line),
    .port_c_line(port_c_line), .core_op(core_op), .core_req(core_req),
    .master_request_enable(master_request_enable), .irq_out(irq_out)
);
`default_nettype wire

// [dv/ipe_core_model.sv]
// partner: processor core issuing unmask, return, mask and acknowledge
`timescale 1ns/1ps
`default_nettype none
module ipe_core_model
(
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic [3:0] op_cmd, // 3 unmask, 2 return, 1 mask, 0 ack
    input wire ipe_pkg::ipe_req_t core_req,
    output ipe_pkg::ipe_core_op_t core_op
);
    ipe_pkg::ipe_core_op_t op_nxt; // next op pulse
    // decode commands; a core only acks a request it sees on offer
    always_comb
    begin
        op_nxt = '0;
        op_nxt.global_unmask_op = op_cmd[3];
        op_nxt.return_from_handler_op = op_cmd[2];
        op_nxt.interrupt_mask_op = op_cmd[1];
        op_nxt.ack = op_cmd[0] & core_req.valid;
        op_nxt.ack_line = core_req.line;
    end
    // ops leave as one-cycle pulses
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            core_op <= '0;
        else
            core_op <= op_nxt;
    end
endmodule
`default_nettype wire

// [dv/ipe_irq_ctrl_tb.sv]
// testbench: register, edge, priority and master enable scenarios
`timescale 1ns/1ps
`default_nettype none
module ipe_irq_ctrl_tb;
    logic sys_clk, reset_n, reg_wr, reg_rd; // clock, reset, strobes
    logic [11:0] reg_addr; // bus address
    logic [7:0] reg_wdata, reg_rdata, port_a_line; // bus data, pins
    logic [3:0] port_c_line, op_cmd; // pins, core commands
    logic master_request_enable, irq_out; // observed levels
    ipe_pkg::ipe_core_op_t core_op; // model to design
    ipe_pkg::ipe_req_t core_req; // design to model
    int num_errors, checked; // verdict counters

    ipe_irq_ctrl uut (.sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .port_a_line(port_a_line), .port_c_line(port_c_line), .core_op(core_op),
        .core_req(core_req), .master_request_enable(master_request_enable),
        .irq_out(irq_out));
    ipe_core_model u_core (.sys_clk(sys_clk), .reset_n(reset_n), .op_cmd(op_cmd),
        .core_req(core_req), .core_op(core_op));

    // free-running clock
    always #5 sys_clk = ~sys_clk;

    task automatic conclude();
        if (num_errors == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    // wait edges, then let their updates land
    task automatic settle(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    // read; data stand only in the cycle after the strobe
    task automatic rdc(input logic [11:0] a, input logic [7:0] exp);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, exp);
    endtask
    task automatic op(input logic [3:0] c);
        @(posedge sys_clk);
        op_cmd <= c;
        @(posedge sys_clk);
        op_cmd <= 4'h0;
        settle(3);
    endtask

    // hang guard
    initial
    begin
        #100000;
        num_errors++;
        conclude();
    end

    initial
    begin
        sys_clk = 1'b0;
        reset_n = 1'b0;
        {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
        {port_a_line, port_c_line, op_cmd} = '0;
        num_errors = 0;
        checked = 0;
        repeat (6) @(posedge sys_clk);
        reset_n <= 1'b1;
        // reset values, unmapped place, legal writes with reserved bits zero
        rdc(ipe_pkg::PORTC_PRIO_HIGH_ADDR, 8'h00);
        rdc(ipe_pkg::PORTC_PRIO_LOW_ADDR, 8'h00);
        rdc(ipe_pkg::EDGE_POLARITY_ADDR, 8'h00);
        rdc(ipe_pkg::REQUEST_CONTROL_ADDR, 8'h00);
        rdc(12'h0fc0, 8'h00);
        wr(ipe_pkg::PORTC_PRIO_HIGH_ADDR, 8'h0f);
        rdc(ipe_pkg::PORTC_PRIO_HIGH_ADDR, 8'h0f);
        wr(ipe_pkg::PORTC_PRIO_LOW_ADDR, 8'h05);
        rdc(ipe_pkg::PORTC_PRIO_LOW_ADDR, 8'h05);
        wr(ipe_pkg::REQUEST_CONTROL_ADDR, 8'h80);
        rdc(ipe_pkg::REQUEST_CONTROL_ADDR, 8'h80);
        wr(ipe_pkg::REQUEST_CONTROL_ADDR, 8'h00);
        rdc(ipe_pkg::REQUEST_CONTROL_ADDR, 8'h00);
        // low half rising, high half falling
        wr(ipe_pkg::EDGE_POLARITY_ADDR, 8'h0f);
        wr(ipe_pkg::PORTA_MASK_ADDR, 8'hff);
        port_a_line <= 8'hff;
        settle(6);
        chk({7'h00, irq_out}, 8'h01);
        rdc(ipe_pkg::PORTA_STATUS_ADDR, 8'h0f);
        // pins held high must not set again
        wr(ipe_pkg::PORTA_STATUS_ADDR, 8'hff);
        rdc(ipe_pkg::PORTA_STATUS_ADDR, 8'h00);
        chk({7'h00, irq_out}, 8'h00);
        @(posedge sys_clk);
        port_a_line <= 8'h00;
        settle(6);
        rdc(ipe_pkg::PORTA_STATUS_ADDR, 8'hf0);
        wr(ipe_pkg::PORTA_MASK_ADDR, 8'h0f);
        settle(2);
        chk({7'h00, irq_out}, 8'h00);
        wr(ipe_pkg::PORTA_STATUS_ADDR, 8'hf0);
        // two-clock pulse on line 0, edge aligned
        port_a_line <= 8'h01;
        repeat (2) @(posedge sys_clk);
        port_a_line <= 8'h00;
        settle(6);
        rdc(ipe_pkg::PORTA_STATUS_ADDR, 8'h01);
        // port C line k gets level k, line 0 off
        wr(ipe_pkg::PORTC_PRIO_HIGH_ADDR, 8'h0c);
        wr(ipe_pkg::PORTC_PRIO_LOW_ADDR, 8'h0a);
        wr(ipe_pkg::PORTC_MASK_ADDR, 8'h0f);
        port_c_line <= 4'hf;
        settle(6);
        chk({3'h0, core_req}, 8'h00);
        for (int k = 3; k > 0; k--)
        begin
            op(k == 2 ? 4'h8 : 4'h4);
            chk({3'h0, core_req}, {4'h1, k[1:0], k[1:0]});
            op(4'h1);
            chk({7'h00, master_request_enable}, 8'h00);
        end
        op(4'h8);
        chk({7'h00, master_request_enable}, 8'h01);
        chk({3'h0, core_req}, 8'h00);
        rdc(ipe_pkg::PORTC_STATUS_ADDR, 8'h01);
        // write one clears the leftover port C bit
        wr(ipe_pkg::PORTC_STATUS_ADDR, 8'h01);
        rdc(ipe_pkg::PORTC_STATUS_ADDR, 8'h00);
        op(4'h2);
        chk({7'h00, master_request_enable}, 8'h00);
        // mid-run reset drops a set master enable
        wr(ipe_pkg::REQUEST_CONTROL_ADDR, 8'h80);
        reset_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        reset_n <= 1'b1;
        rdc(ipe_pkg::REQUEST_CONTROL_ADDR, 8'h00);
        conclude();
    end
endmodule
`default_nettype wire
